//--- rdc_pkg.sv
package rdc_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_THIRD_LDO_CONTROL = 8'h29;
  localparam logic [7:0] OFS_DISCHARGE_SELECT_A = 8'h40;
  localparam logic [7:0] OFS_DISCHARGE_SELECT_B = 8'h41;

  // ==========================================================
  // Field layout and counts
  localparam int NUM_RAILS = 8;
  localparam int FIELD_W = 2;
  localparam int FIELDS_PER_REG = 4;
  localparam int LDO3_EN_POS = 0;
  localparam int LDO3_RSV_LSB = 1;
  localparam int LDO3_RSV_MSB = 3;
  localparam int LDO3_SLP_LSB = 4;
  localparam int LDO3_SLP_MSB = 5;

  // Rail index of each discharge field
  localparam int RAIL_BUCK1 = 0;
  localparam int RAIL_BUCK2 = 1;
  localparam int RAIL_BUCK3 = 2;
  localparam int RAIL_BUCK4 = 3;
  localparam int RAIL_BUCK5 = 4;
  localparam int RAIL_BUCK6 = 5;
  localparam int RAIL_SWITCH_A1 = 6;
  localparam int RAIL_LDO2 = 7;

  // ==========================================================
  // Discharge selection codes
  localparam logic [1:0] DIS_NONE = 2'h0;
  localparam logic [1:0] DIS_100_OHM = 2'h1;
  localparam logic [1:0] DIS_200_OHM = 2'h2;
  localparam logic [1:0] DIS_500_OHM = 2'h3;

  // ==========================================================
  // Values after reset
  localparam logic [1:0] DIS_FIELD_RESET = DIS_100_OHM;
  localparam logic [7:0] THIRD_LDO_CONTROL_RESET = 8'h0D;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

endpackage

//--- rdc_dis_field.sv
`timescale 1ns/10ps
module rdc_dis_field (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic wr_i,
  input wire logic [1:0] wdata_i,
  input wire logic rail_on_i,
  output logic [1:0] sel_o,
  output logic path_100_o,
  output logic path_200_o,
  output logic path_500_o
);

  logic [1:0] next_sel;
  logic next_path_100;
  logic next_path_200;
  logic next_path_500;

  // ==========================================================
  // Field update and decode
  always_comb begin
    next_sel = sel_o;
    if (wr_i) begin
      next_sel = wdata_i;
    end
    // Enabled rail holds the field at zero; beats a same-cycle write
    if (rail_on_i) begin
      next_sel = rdc_pkg::DIS_NONE;
    end
    next_path_100 = (next_sel == rdc_pkg::DIS_100_OHM);
    next_path_200 = (next_sel == rdc_pkg::DIS_200_OHM);
    next_path_500 = (next_sel == rdc_pkg::DIS_500_OHM);
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sel_o <= rdc_pkg::DIS_FIELD_RESET;
      path_100_o <= 1'b1;
      path_200_o <= 1'b0;
      path_500_o <= 1'b0;
    end else begin
      sel_o <= next_sel;
      path_100_o <= next_path_100;
      path_200_o <= next_path_200;
      path_500_o <= next_path_500;
    end
  end

endmodule

//--- rdc_regs.sv
`timescale 1ns/10ps
module rdc_regs #(
  parameter int NUM_RAILS = rdc_pkg::NUM_RAILS,
  parameter int FIELD_W = rdc_pkg::FIELD_W,
  parameter int FIELDS_PER_REG = rdc_pkg::FIELDS_PER_REG
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] rail_on_i,
  input wire logic ldo3_pin_request_i,
  output logic [7:0] reg_rdata_o,
  output logic [7:0] discharge_100_o,
  output logic [7:0] discharge_200_o,
  output logic [7:0] discharge_500_o,
  output logic third_ldo_on_o,
  output logic [1:0] third_ldo_sleep_en_o
);

  // ==========================================================
  // Declarations
  logic [7:0] third_ldo_control;
  logic [7:0] next_third_ldo_control;
  logic pin_meta;
  logic pin_sync;
  logic next_third_ldo_on;
  logic [7:0] next_rdata;
  logic [15:0] dis_fields;
  logic wr_a;
  logic wr_b;
  logic wr_ldo3;
  logic hit_a;
  logic hit_b;
  logic hit_ldo3;
  logic next_pin_meta;
  logic next_pin_sync;
  logic next_ldo3_enable;
  logic [2:0] next_ldo3_reserved;
  logic [1:0] next_ldo3_sleep;
  logic [1:0] next_sleep_en;
  logic [7:0] word_a;
  logic [7:0] word_b;

  // ==========================================================
  // Elaboration checks
  // Port widths are fixed at eight rails of two-bit fields
  if (NUM_RAILS != 8) begin : g_bad_rails
    $error("rdc_regs needs NUM_RAILS of 8");
  end
  if (FIELD_W != 2) begin : g_bad_field
    $error("rdc_regs needs FIELD_W of 2");
  end
  if (FIELDS_PER_REG * FIELD_W != 8) begin : g_bad_pack
    $error("rdc_regs fields must fill one byte");
  end
  // Register B pairing assumes this rail order
  if (rdc_pkg::RAIL_BUCK1 != 0 ||
      rdc_pkg::RAIL_BUCK5 != FIELDS_PER_REG ||
      rdc_pkg::RAIL_LDO2 != NUM_RAILS - 1) begin : g_bad_map
    $error("rdc_regs rail order does not match the registers");
  end

  // ==========================================================
  // Offset decode
  // Unmapped offsets hit nothing, so stray writes are dropped
  always_comb begin
    hit_a = 1'b0;
    hit_b = 1'b0;
    hit_ldo3 = 1'b0;
    case (reg_addr_i)
      rdc_pkg::OFS_DISCHARGE_SELECT_A: begin
        hit_a = 1'b1;
      end
      rdc_pkg::OFS_DISCHARGE_SELECT_B: begin
        hit_b = 1'b1;
      end
      rdc_pkg::OFS_THIRD_LDO_CONTROL: begin
        hit_ldo3 = 1'b1;
      end
      default: begin
        hit_a = 1'b0;
      end
    endcase
    wr_a = reg_wr_i && hit_a;
    wr_b = reg_wr_i && hit_b;
    wr_ldo3 = reg_wr_i && hit_ldo3;
  end

  // ==========================================================
  // Discharge fields, one cell per rail
  // Rails 0..3 live in register A, 4..7 in register B
  genvar g;
  generate
    for (g = 0; g < NUM_RAILS; g = g + 1) begin : g_rail
      logic cell_wr;
      if (g < FIELDS_PER_REG) begin : g_a
        assign cell_wr = wr_a;
      end else begin : g_b
        assign cell_wr = wr_b;
      end
      rdc_dis_field u_field (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(cell_wr),
        .wdata_i(reg_wdata_i[(g % FIELDS_PER_REG) * FIELD_W +: FIELD_W]),
        .rail_on_i(rail_on_i[g]),
        .sel_o(dis_fields[g * FIELD_W +: FIELD_W]),
        .path_100_o(discharge_100_o[g]),
        .path_200_o(discharge_200_o[g]),
        .path_500_o(discharge_500_o[g])
      );
    end
  endgenerate

  // ==========================================================
  // Register words, one slot per rail
  genvar w;
  generate
    for (w = 0; w < NUM_RAILS; w = w + 1) begin : g_word
      if (w < FIELDS_PER_REG) begin : g_in_a
        assign word_a[w * FIELD_W +: FIELD_W] =
          dis_fields[w * FIELD_W +: FIELD_W];
      end else begin : g_in_b
        assign word_b[(w - FIELDS_PER_REG) * FIELD_W +: FIELD_W] =
          dis_fields[w * FIELD_W +: FIELD_W];
      end
    end
  endgenerate

  // ==========================================================
  // Control pin synchroniser
  // Two stages; only the second stage feeds any logic
  always_comb begin
    next_pin_meta = ldo3_pin_request_i;
    next_pin_sync = pin_meta;
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      pin_meta <= next_pin_meta;
      pin_sync <= next_pin_sync;
    end
  end

  // ==========================================================
  // Third LDO control register
  // Bits 7:6 are read-only zero; reserved 3:1 stay writable
  always_comb begin
    next_ldo3_enable = third_ldo_control[rdc_pkg::LDO3_EN_POS];
    next_ldo3_reserved =
      third_ldo_control[rdc_pkg::LDO3_RSV_MSB:rdc_pkg::LDO3_RSV_LSB];
    next_ldo3_sleep =
      third_ldo_control[rdc_pkg::LDO3_SLP_MSB:rdc_pkg::LDO3_SLP_LSB];
    if (wr_ldo3) begin
      next_ldo3_enable = reg_wdata_i[rdc_pkg::LDO3_EN_POS];
      next_ldo3_reserved =
        reg_wdata_i[rdc_pkg::LDO3_RSV_MSB:rdc_pkg::LDO3_RSV_LSB];
      next_ldo3_sleep =
        reg_wdata_i[rdc_pkg::LDO3_SLP_MSB:rdc_pkg::LDO3_SLP_LSB];
    end
    next_third_ldo_control = {
      2'h0,
      next_ldo3_sleep,
      next_ldo3_reserved,
      next_ldo3_enable
    };
    next_sleep_en = next_ldo3_sleep;
    // Software disable overrides whatever the pins request
    next_third_ldo_on = pin_sync && next_ldo3_enable;
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      third_ldo_control <= rdc_pkg::THIRD_LDO_CONTROL_RESET;
      third_ldo_on_o <= 1'b0;
      third_ldo_sleep_en_o <= 2'h0;
    end else begin
      third_ldo_control <= next_third_ldo_control;
      third_ldo_on_o <= next_third_ldo_on;
      third_ldo_sleep_en_o <= next_sleep_en;
    end
  end

  // ==========================================================
  // Read-back, one cycle after the address
  always_comb begin
    case (reg_addr_i)
      rdc_pkg::OFS_DISCHARGE_SELECT_A: begin
        next_rdata = word_a;
      end
      rdc_pkg::OFS_DISCHARGE_SELECT_B: begin
        next_rdata = word_b;
      end
      rdc_pkg::OFS_THIRD_LDO_CONTROL: begin
        next_rdata = third_ldo_control;
      end
      default: begin
        next_rdata = rdc_pkg::READ_UNMAPPED;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= rdc_pkg::READ_UNMAPPED;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

endmodule

//--- rdc_props.sv
`timescale 1ns/10ps
module rdc_props (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] rail_on_i,
  input wire logic ldo3_pin_request_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [7:0] discharge_100_o,
  input wire logic [7:0] discharge_200_o,
  input wire logic [7:0] discharge_500_o,
  input wire logic third_ldo_on_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic wa;
  assign wa = reg_wr_i && reg_addr_i == 8'h40 && rail_on_i[3:0] == 4'h0;
  a_ldo_off: assert property (reg_wr_i && reg_addr_i == 8'h29 &&
    !reg_wdata_i[0] |-> ##2 !third_ldo_on_o) else $error("ldo still on");
  a_rail_clr: assert property (|rail_on_i |=> ((discharge_100_o |
    discharge_200_o | discharge_500_o) & $past(rail_on_i)) == 8'h00)
    else $error("path on for enabled rail");
  a_code_decode: assert property (wa && reg_wdata_i == 8'hE4 |=>
    discharge_100_o[3:0] == 4'h2 && discharge_200_o[3:0] == 4'h4 &&
    discharge_500_o[3:0] == 4'h8) else $error("bad decode");
  a_read_back: assert property (wa ##1 (reg_addr_i == 8'h40 &&
    rail_on_i[3:0] == 4'h0) |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("bad readback");
  a_b_clear: assert property (rail_on_i[7] ##1 reg_addr_i == 8'h41 |=>
    reg_rdata_o[7:6] == 2'h0) else $error("field not cleared");
  a_pin_gate: assert property (!ldo3_pin_request_i |-> ##3
    !third_ldo_on_o) else $error("ldo on without pin request");
  c_write: cover property (wa ##1 reg_addr_i == 8'h40);
  c_clear: cover property (|rail_on_i ##1 reg_wr_i);
  c_ldo: cover property (third_ldo_on_o ##1 !third_ldo_on_o);
endmodule

bind rdc_regs rdc_props u_props (.*);

//--- rdc_host.sv
`timescale 1ns/10ps
module rdc_host (
  input wire logic ref_clk_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o
);
  // Idle on an unmapped offset so stray reads stay harmless
  initial begin
    addr_o = 8'hFF;
    wdata_o = 8'h00;
    wr_o = 1'b0;
  end
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge ref_clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    addr_o <= a;
    repeat (2) @(posedge ref_clk_i);
    #1 d = rdata_i;
  endtask
endmodule

//--- tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic pin = 1'b0;
  logic [7:0] rail = 8'h00;
  logic [7:0] addr, wdata, rdata, d100, d200, d500;
  logic wr, on;
  logic [1:0] slp;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  rdc_host host (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr));
  rdc_regs dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .rail_on_i(rail),
    .ldo3_pin_request_i(pin), .reg_rdata_o(rdata), .discharge_100_o(d100),
    .discharge_200_o(d200), .discharge_500_o(d500), .third_ldo_on_o(on),
    .third_ldo_sleep_en_o(slp));
  initial forever #25 ref_clk_i = ~ref_clk_i;
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.get(a, d);
    chk("rdata", d, e);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hang guard, the tests need about 60 cycles
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count++;
      finish_test();
    end
  end
  // ==========================================================
  // Tests
  initial begin
    repeat (4) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    rd(8'h40, 8'h55);
    rd(8'h41, 8'h55);
    chk("d100", d100, 8'hFF);
    rd(8'h10, 8'h00);
    $display("reset test done");
    host.put(8'h41, 8'hDB);
    host.put(8'h40, 8'hE4);
    rd(8'h40, 8'hE4);
    rd(8'h41, 8'hDB);
    chk("d100", d100, 8'h42);
    chk("d200", d200, 8'h24);
    chk("d500", d500, 8'h98);
    $display("decode test done");
    @(posedge ref_clk_i) rail <= 8'h88;
    rd(8'h40, 8'h24);
    rd(8'h41, 8'h1B);
    host.put(8'h40, 8'hFF);
    @(posedge ref_clk_i) rail <= 8'h00;
    rd(8'h40, 8'h3F);
    chk("d500", d500, 8'h17);
    $display("clear test done");
    @(posedge ref_clk_i) pin <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    #1 chk("ldo_on", {7'h00, on}, 8'h01);
    host.put(8'h29, 8'hFC);
    repeat (2) @(posedge ref_clk_i);
    #1 chk("ldo_on", {7'h00, on}, 8'h00);
    chk("sleep_en", {6'h00, slp}, 8'h03);
    rd(8'h29, 8'h3C);
    host.put(8'h29, 8'h0D);
    repeat (2) @(posedge ref_clk_i);
    #1 chk("ldo_on", {7'h00, on}, 8'h01);
    chk("sleep_en", {6'h00, slp}, 8'h00);
    @(posedge ref_clk_i) pin <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #1 chk("ldo_on", {7'h00, on}, 8'h00);
    $display("ldo test done");
    finish_test();
  end
endmodule
